// ==== azm_audio_src.sv ====
`timescale 1ns/1ps
module azm_audio_src
	import azm_pkg::*;
(
	// Link clock and reset
	input wire logic frame_clock,
	input wire logic frame_rst_n,
	// Scenario control
	input wire logic silent,
	// Samples toward the block
	output azm_frame_s frame_in
);
	logic [15:0] seq_reg;
	////////////////////////////////////////////////////////////////
	// Pattern moves every frame, so a stale sample never looks new
	always_ff @(posedge frame_clock)
	begin
		if (!frame_rst_n)
			seq_reg <= 16'h0000;
		else
			seq_reg <= seq_reg + 16'h0001;
	end
	assign frame_in = silent ? '0 : {seq_reg, 16'h0001, 16'h0001, seq_reg};
endmodule

// ==== azm_pkg.sv ====
package azm_pkg;
	// Register word indices (printed offsets are word indices; byte address = 4 x index)
	localparam logic [7:0] AZM_IDX_ENABLE = 8'h02;
	localparam logic [7:0] AZM_IDX_ZTHR = 8'h3B;
	localparam logic [7:0] AZM_IDX_RAMP = 8'h3F;
	localparam logic [7:0] AZM_IDX_EMRG = 8'h40;
	localparam logic [7:0] AZM_IDX_ZCTL = 8'h41;
	localparam logic [7:0] AZM_IDX_STATUS = 8'h50;
	localparam logic [7:0] AZM_IDX_VOLUME = 8'h51;
	// Reset values
	localparam logic [7:0] AZM_RST_ENABLE = 8'h01;
	localparam logic [7:0] AZM_RST_ZTHR = 8'h00;
	localparam logic [7:0] AZM_RST_RAMP = 8'h33;
	localparam logic [7:0] AZM_RST_EMRG = 8'h00;
	localparam logic [7:0] AZM_RST_ZCTL = 8'h07;
	localparam logic [7:0] AZM_RST_VOLUME = 8'h00;
	// Field positions
	localparam int AZM_ZCTL_AND = 2;
	localparam int AZM_ZCTL_ENR = 1;
	localparam int AZM_ZCTL_ENL = 0;
	// Volume counts in 0.5 dB units; max attenuation code
	localparam logic [7:0] AZM_VOL_MUTE = 8'hFF;
	// Zero-count thresholds in frames
	localparam logic [18:0] AZM_ZT0 = 19'd1024;
	localparam logic [18:0] AZM_ZT1 = 19'd5120;
	localparam logic [18:0] AZM_ZT2 = 19'd10240;
	localparam logic [18:0] AZM_ZT3 = 19'd25600;
	localparam logic [18:0] AZM_ZT4 = 19'd51200;
	localparam logic [18:0] AZM_ZT5 = 19'd102400;
	localparam logic [18:0] AZM_ZT6 = 19'd256000;
	localparam logic [18:0] AZM_ZT7 = 19'd512000;
	// Strap decode
	localparam logic [2:0] AZM_STRAP_RESERVED = 3'h7;
	localparam logic [1:0] AZM_GAIN_20DB = 2'h0;
	localparam logic [1:0] AZM_GAIN_26DB = 2'h1;
	localparam logic [1:0] AZM_GAIN_RSVD = 2'h3;

	typedef struct packed {
		logic [7:0] gain_db;
		logic [3:0] freq_mult;
		logic [15:0] sync_khz_x10;
		logic reserved;
	} azm_amp_cfg_s;

	typedef struct packed {
		logic [31:0] left;
		logic [31:0] right;
	} azm_frame_s;
endpackage

// ==== azm_zero_mute_ramp.sv ====
`timescale 1ns/1ps
// How it works
// - Control bit 2 picks OR (0) or AND (1, default) of zero triggers.
// - Count consecutive zero frames per channel; trigger at that channel's threshold.
// - Threshold codes 0..7 mean 1024 up to 512000 zero frames.
// - Both threshold fields reset to code zero.
// - Control bit 1 enables right-channel detection and mute, default on.
// - Control bit 0 enables left-channel detection and mute, default on.
// - No audio until host writes 0x00 to enable register 0x02.
// - Ramp-up rate bits 7:6, ramp-down rate bits 3:2.
// - Rate codes: every 1, 2, 4 samples, or immediate change.
// - Ramp-up step bits 5:4, ramp-down step bits 1:0.
// - Step codes mean 4, 2, 1, 0.5 dB; 0.5 dB default.
// - Clock error or supply fail ramps down with emergency rate and step.
// - Emergency default is every sample, 4 dB step.
// - Strap digitized at start-up into 3-bit gain and frequency code.
// - Strap latched once, ignored until power stage supply cycles.
// - Ranges 4 to 6 are 26 dB, range 7 reserved, lower four 20 dB; frequency 8,6,5,4 x sync.
// - Sync rate 96 kHz or 88.2 kHz by sample-rate family.
module azm_zero_mute_ramp
	import azm_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite slave
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Audio link, frame_clock domain
	input wire logic frame_clock,
	input wire logic frame_rst_n,
	input wire azm_frame_s frame_in,
	// Fault and start-up inputs (asynchronous)
	input wire logic clock_error,
	input wire logic supply_fail,
	input wire logic power_stage_up,
	input wire logic [2:0] gain_freq_strap,
	input wire logic rate_family_441,
	// Outputs
	output logic play_enable,
	output logic mute_left,
	output logic mute_right,
	output logic [7:0] volume_atten,
	output azm_amp_cfg_s amp_cfg
);

	////////////////////////////////////////////////////////////////////////////
	function automatic logic [18:0] zthr(input logic [2:0] code);
		case (code)
			3'h0: zthr = AZM_ZT0;
			3'h1: zthr = AZM_ZT1;
			3'h2: zthr = AZM_ZT2;
			3'h3: zthr = AZM_ZT3;
			3'h4: zthr = AZM_ZT4;
			3'h5: zthr = AZM_ZT5;
			3'h6: zthr = AZM_ZT6;
			default: zthr = AZM_ZT7;
		endcase
	endfunction

	// Step in 0.5 dB units
	function automatic logic [7:0] step_half_db(input logic [1:0] code);
		case (code)
			2'h0: step_half_db = 8'h08;
			2'h1: step_half_db = 8'h04;
			2'h2: step_half_db = 8'h02;
			default: step_half_db = 8'h01;
		endcase
	endfunction

	// Update spacing in samples; 0 means direct change
	function automatic logic [2:0] rate_div(input logic [1:0] code);
		case (code)
			2'h0: rate_div = 3'h1;
			2'h1: rate_div = 3'h2;
			2'h2: rate_div = 3'h4;
			default: rate_div = 3'h0;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Register file
	logic [7:0] enable_reg, zthr_reg, ramp_reg, emrg_reg, zctl_reg, target_reg;
	logic aw_hold_reg, w_hold_reg;
	logic [11:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;
	logic bvalid_reg, rvalid_reg;
	logic [1:0] bresp_reg, rresp_reg;
	logic [31:0] rdata_reg;

	wire aw_take = s_axi_awvalid && !aw_hold_reg && !bvalid_reg;
	wire w_take = s_axi_wvalid && !w_hold_reg && !bvalid_reg;
	wire aw_have = aw_hold_reg || aw_take;
	wire w_have = w_hold_reg || w_take;
	wire wr_go = aw_have && w_have && !bvalid_reg;
	wire [11:0] wr_addr = aw_hold_reg ? awaddr_reg : s_axi_awaddr;
	wire [31:0] wr_data = w_hold_reg ? wdata_reg : s_axi_wdata;
	wire [3:0] wr_strb = w_hold_reg ? wstrb_reg : s_axi_wstrb;
	wire wr_lane0 = wr_go && wr_strb[0] && (wr_addr[1:0] == 2'h0);
	wire [9:0] wr_idx = wr_addr[11:2];
	wire wr_en = wr_lane0 && (wr_idx == {2'h0, AZM_IDX_ENABLE});
	wire wr_zt = wr_lane0 && (wr_idx == {2'h0, AZM_IDX_ZTHR});
	wire wr_rp = wr_lane0 && (wr_idx == {2'h0, AZM_IDX_RAMP});
	wire wr_em = wr_lane0 && (wr_idx == {2'h0, AZM_IDX_EMRG});
	wire wr_zc = wr_lane0 && (wr_idx == {2'h0, AZM_IDX_ZCTL});
	wire wr_vol = wr_lane0 && (wr_idx == {2'h0, AZM_IDX_VOLUME});
	wire wr_hit = wr_en || wr_zt || wr_rp || wr_em || wr_zc || wr_vol;

	assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
	assign s_axi_wready = !w_hold_reg && !bvalid_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_hold_reg <= 1'b0;
			w_hold_reg <= 1'b0;
			awaddr_reg <= 12'h000;
			wdata_reg <= 32'h00000000;
			wstrb_reg <= 4'h0;
		end
		else
		begin
			aw_hold_reg <= aw_have && !wr_go;
			w_hold_reg <= w_have && !wr_go;
			if (aw_take)
				awaddr_reg <= s_axi_awaddr;
			if (w_take)
			begin
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bvalid_reg <= 1'b0;
			bresp_reg <= 2'h0;
		end
		else if (wr_go)
		begin
			bvalid_reg <= 1'b1;
			bresp_reg <= wr_hit ? 2'h0 : 2'h2;
		end
		else if (s_axi_bready)
			bvalid_reg <= 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			enable_reg <= AZM_RST_ENABLE;
			zthr_reg <= AZM_RST_ZTHR;
			ramp_reg <= AZM_RST_RAMP;
			emrg_reg <= AZM_RST_EMRG;
			zctl_reg <= AZM_RST_ZCTL;
			target_reg <= AZM_RST_VOLUME;
		end
		else
		begin
			if (wr_en)
				enable_reg <= wr_data[7:0];
			if (wr_zt)
				zthr_reg <= wr_data[7:0];
			if (wr_rp)
				ramp_reg <= wr_data[7:0];
			if (wr_em)
				emrg_reg <= wr_data[7:0];
			if (wr_zc)
				zctl_reg <= wr_data[7:0];
			if (wr_vol)
				target_reg <= wr_data[7:0];
		end
	end

	// Device stays silent until enable register reads zero
	assign play_enable = (enable_reg == 8'h00);

	////////////////////////////////////////////////////////////////////////////
	// Synchronisers into aclk
	logic [1:0] cerr_sync, sfail_sync, pwr_sync, fam_sync;
	logic [2:0] strap_s1, strap_s2;
	logic mute_l_fc, mute_r_fc;
	logic [1:0] ml_sync, mr_sync;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cerr_sync <= 2'h0;
			sfail_sync <= 2'h0;
			pwr_sync <= 2'h0;
			fam_sync <= 2'h0;
			strap_s1 <= 3'h0;
			strap_s2 <= 3'h0;
			ml_sync <= 2'h0;
			mr_sync <= 2'h0;
		end
		else
		begin
			cerr_sync <= {cerr_sync[0], clock_error};
			sfail_sync <= {sfail_sync[0], supply_fail};
			pwr_sync <= {pwr_sync[0], power_stage_up};
			fam_sync <= {fam_sync[0], rate_family_441};
			strap_s1 <= gain_freq_strap;
			strap_s2 <= strap_s1;
			ml_sync <= {ml_sync[0], mute_l_fc};
			mr_sync <= {mr_sync[0], mute_r_fc};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Strap capture on power stage rise; held until it drops and rises again
	logic pwr_prev_reg, strap_valid_reg;
	logic [2:0] strap_reg;
	wire pwr_rise = pwr_sync[1] && !pwr_prev_reg;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pwr_prev_reg <= 1'b0;
			strap_valid_reg <= 1'b0;
			strap_reg <= 3'h0;
		end
		else
		begin
			pwr_prev_reg <= pwr_sync[1];
			if (pwr_rise)
			begin
				strap_reg <= strap_s2;
				strap_valid_reg <= 1'b1;
			end
		end
	end

	wire strap_rsvd = (strap_reg == AZM_STRAP_RESERVED);
	wire [1:0] gain_sel = strap_rsvd ? AZM_GAIN_RSVD :
		(strap_reg[2] ? AZM_GAIN_26DB : AZM_GAIN_20DB);
	wire [3:0] freq_sel = (strap_reg[1:0] == 2'h3) ? 4'h8 :
		(strap_reg[1:0] == 2'h2) ? 4'h6 :
		(strap_reg[1:0] == 2'h1) ? 4'h5 : 4'h4;
	always_comb
	begin
		amp_cfg.gain_db = (gain_sel == AZM_GAIN_26DB) ? 8'h1A : 8'h14;
		amp_cfg.freq_mult = strap_rsvd ? 4'h0 : freq_sel;
		amp_cfg.sync_khz_x10 = fam_sync[1] ? 16'h0372 : 16'h03C0;
		amp_cfg.reserved = strap_rsvd || !strap_valid_reg;
	end

	////////////////////////////////////////////////////////////////////////////
	// Frame-clock domain: zero detection
	logic [1:0] zctl_fc1, zctl_fc2;
	logic and_fc1, and_fc2;
	logic [7:0] zthr_fc1, zthr_fc2, zthr_fc_reg;
	logic [18:0] cnt_l_reg, cnt_r_reg;
	// Threshold word taken only once two synchronised copies agree
	wire [18:0] thr_l = zthr(zthr_fc_reg[6:4]);
	wire [18:0] thr_r = zthr(zthr_fc_reg[2:0]);
	wire zero_l = (frame_in.left == 32'h00000000);
	wire zero_r = (frame_in.right == 32'h00000000);
	wire trig_l = zctl_fc2[0] && (cnt_l_reg >= thr_l - 19'd1) && zero_l;
	wire trig_r = zctl_fc2[1] && (cnt_r_reg >= thr_r - 19'd1) && zero_r;
	wire both = and_fc2 ? (trig_l && trig_r) : (trig_l || trig_r);
	always_ff @(posedge frame_clock)
	begin
		if (!frame_rst_n)
		begin
			zctl_fc1 <= 2'h0;
			zctl_fc2 <= 2'h0;
			and_fc1 <= 1'b0;
			and_fc2 <= 1'b0;
			zthr_fc1 <= AZM_RST_ZTHR;
			zthr_fc2 <= AZM_RST_ZTHR;
			zthr_fc_reg <= AZM_RST_ZTHR;
			cnt_l_reg <= 19'd0;
			cnt_r_reg <= 19'd0;
			mute_l_fc <= 1'b0;
			mute_r_fc <= 1'b0;
		end
		else
		begin
			zctl_fc1 <= {zctl_reg[AZM_ZCTL_ENR], zctl_reg[AZM_ZCTL_ENL]};
			zctl_fc2 <= zctl_fc1;
			and_fc1 <= zctl_reg[AZM_ZCTL_AND];
			and_fc2 <= and_fc1;
			zthr_fc1 <= zthr_reg;
			zthr_fc2 <= zthr_fc1;
			if (zthr_fc2 == zthr_fc1)
				zthr_fc_reg <= zthr_fc2;
			cnt_l_reg <= (!zero_l || !zctl_fc2[0]) ? 19'd0 :
				(cnt_l_reg == AZM_ZT7) ? cnt_l_reg : cnt_l_reg + 19'd1;
			cnt_r_reg <= (!zero_r || !zctl_fc2[1]) ? 19'd0 :
				(cnt_r_reg == AZM_ZT7) ? cnt_r_reg : cnt_r_reg + 19'd1;
			mute_l_fc <= both && zctl_fc2[0];
			mute_r_fc <= both && zctl_fc2[1];
		end
	end

	assign mute_left = ml_sync[1];
	assign mute_right = mr_sync[1];

	////////////////////////////////////////////////////////////////////////////
	// Volume ramp, paced by frame toggles crossed into aclk
	logic tick_fc;
	logic [2:0] tick_sync;
	always_ff @(posedge frame_clock)
	begin
		if (!frame_rst_n)
			tick_fc <= 1'b0;
		else
			tick_fc <= !tick_fc;
	end

	logic [7:0] vol_reg;
	logic [2:0] div_reg;
	wire sample = tick_sync[2] ^ tick_sync[1];
	wire emerg = cerr_sync[1] || sfail_sync[1];
	wire [7:0] goal = emerg ? AZM_VOL_MUTE : target_reg;
	wire going_down = goal > vol_reg;
	wire [1:0] rate_code = emerg ? emrg_reg[7:6] :
		(going_down ? ramp_reg[3:2] : ramp_reg[7:6]);
	wire [1:0] step_code = emerg ? emrg_reg[5:4] :
		(going_down ? ramp_reg[1:0] : ramp_reg[5:4]);
	wire [2:0] spacing = rate_div(rate_code);
	wire [7:0] step = step_half_db(step_code);
	wire [7:0] gap = going_down ? goal - vol_reg : vol_reg - goal;
	wire [7:0] move = (gap < step) ? gap : step;
	wire due = sample && (div_reg + 3'h1 >= spacing);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			tick_sync <= 3'h0;
			div_reg <= 3'h0;
			vol_reg <= AZM_VOL_MUTE;
		end
		else
		begin
			tick_sync <= {tick_sync[1:0], tick_fc};
			if (spacing == 3'h0)
				vol_reg <= goal;
			else if (due)
			begin
				div_reg <= 3'h0;
				vol_reg <= going_down ? vol_reg + move : vol_reg - move;
			end
			else if (sample)
				div_reg <= div_reg + 3'h1;
		end
	end

	assign volume_atten = play_enable ? vol_reg : AZM_VOL_MUTE;

	////////////////////////////////////////////////////////////////////////////
	// Read channel
	wire [9:0] rd_idx = s_axi_araddr[11:2];
	logic [31:0] rd_mux;
	logic rd_ok;
	always_comb
	begin
		rd_ok = 1'b1;
		rd_mux = 32'h00000000;
		case (rd_idx)
			{2'h0, AZM_IDX_ENABLE}: rd_mux = {24'h000000, enable_reg};
			{2'h0, AZM_IDX_ZTHR}: rd_mux = {24'h000000, zthr_reg};
			{2'h0, AZM_IDX_RAMP}: rd_mux = {24'h000000, ramp_reg};
			{2'h0, AZM_IDX_EMRG}: rd_mux = {24'h000000, emrg_reg};
			{2'h0, AZM_IDX_ZCTL}: rd_mux = {24'h000000, zctl_reg};
			{2'h0, AZM_IDX_VOLUME}: rd_mux = {24'h000000, target_reg};
			{2'h0, AZM_IDX_STATUS}: rd_mux = {16'h0000, vol_reg, 1'b0, emerg,
				strap_valid_reg, strap_reg, mute_right, mute_left};
			default: rd_ok = 1'b0;
		endcase
	end

	assign s_axi_arready = !rvalid_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
			rresp_reg <= 2'h0;
		end
		else if (s_axi_arvalid && !rvalid_reg)
		begin
			rvalid_reg <= 1'b1;
			rdata_reg <= rd_mux;
			rresp_reg <= rd_ok ? 2'h0 : 2'h2;
		end
		else if (s_axi_rready)
			rvalid_reg <= 1'b0;
	end

endmodule

// ==== azm_zero_mute_ramp_asserts.sv ====
`timescale 1ns/1ps
module azm_zero_mute_ramp_asserts
	import azm_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Register bus
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	// Control and status
	input wire logic clock_error,
	input wire logic supply_fail,
	input wire logic power_stage_up,
	input wire logic [7:0] volume_atten,
	input wire azm_amp_cfg_s amp_cfg
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	////////////////////////////////////////////////////////////////
	sequence s_emrg_held;
		(clock_error || supply_fail) [*4];
	endsequence
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
	endproperty
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	property p_aw_block;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	property p_ar_block;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	property p_b_cause;
		$rose(s_axi_bvalid) |-> $past(s_axi_awvalid && s_axi_awready || s_axi_wvalid && s_axi_wready);
	endproperty
	// Emergency only ever adds attenuation
	property p_emrg;
		s_emrg_held |=> volume_atten >= $past(volume_atten);
	endproperty
	property p_strap_hold;
		!$stable({amp_cfg.gain_db, amp_cfg.freq_mult, amp_cfg.reserved}) |-> power_stage_up;
	endproperty
	property p_gain;
		!amp_cfg.reserved |-> (amp_cfg.gain_db == 8'h14 || amp_cfg.gain_db == 8'h1A)
			&& amp_cfg.freq_mult inside {4'h4, 4'h5, 4'h6, 4'h8};
	endproperty
	property p_sync;
		!amp_cfg.reserved |-> amp_cfg.sync_khz_x10 inside {16'h03C0, 16'h0372};
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("bvalid dropped early");
	a_r_hold: assert property (p_r_hold) else $error("read answer unstable");
	a_aw_block: assert property (p_aw_block) else $error("write taken while pending");
	a_ar_block: assert property (p_ar_block) else $error("read taken while pending");
	a_b_cause: assert property (p_b_cause) else $error("response without write");
	a_emrg: assert property (p_emrg) else $error("volume rose in emergency");
	a_strap_hold: assert property (p_strap_hold) else $error("strap config moved");
	a_gain: assert property (p_gain) else $error("bad gain or frequency");
	a_sync: assert property (p_sync) else $error("bad sync rate");
endmodule
bind azm_zero_mute_ramp azm_zero_mute_ramp_asserts chk_u (.*);

// ==== azm_zero_mute_ramp_test.sv ====
`timescale 1ns/1ps
module azm_zero_mute_ramp_test;
	import azm_pkg::*;
	logic aclk = 0, aresetn = 0, frame_clock = 0, frame_rst_n = 0, silent = 0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0;
	logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic clock_error = 0, supply_fail = 0, power_stage_up = 0, rate_family_441 = 0;
	logic [2:0] gain_freq_strap = 0;
	logic play_enable, mute_left, mute_right;
	logic [7:0] volume_atten;
	azm_frame_s frame_in;
	azm_amp_cfg_s amp_cfg;
	int checks = 0, failures = 0;
	always #20 aclk = ~aclk;
	always #32 frame_clock = ~frame_clock;
	azm_zero_mute_ramp dut_u (.*);
	azm_audio_src src_u (.frame_clock(frame_clock), .frame_rst_n(frame_rst_n),
		.silent(silent), .frame_in(frame_in));
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic results;
		$display("checks=%0d failures=%0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Byte address is four times the register index
	task automatic wr(input logic [7:0] i, input logic [7:0] d, output logic [1:0] r);
		logic ad, wd;
		ad = 0;
		wd = 0;
		@(posedge aclk);
		s_axi_awaddr <= {2'h0, i, 2'h0};
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		while (!(ad && wd))
		begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready)
				ad = 1;
			if (s_axi_wvalid && s_axi_wready)
				wd = 1;
			if (ad)
				s_axi_awvalid <= 0;
			if (wd)
				s_axi_wvalid <= 0;
		end
		do @(posedge aclk); while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 0;
	endtask
	task automatic rd(input logic [7:0] i, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= {2'h0, i, 2'h0};
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do @(posedge aclk); while (!(s_axi_arvalid && s_axi_arready));
		s_axi_arvalid <= 0;
		do @(posedge aclk); while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 0;
	endtask
	task automatic rchk(input logic [7:0] i, input logic [7:0] e);
		logic [31:0] d;
		logic [1:0] r;
		rd(i, d, r);
		chk(d, {24'h0, e});
	endtask
	task automatic waitc(input int n);
		repeat (n) @(posedge aclk);
	endtask
	// Both channels silent; mute pair checked below and above the count
	task automatic zrun(input logic [7:0] ctl, thr, input int n1, n2, input logic [1:0] e2);
		logic [1:0] r;
		wr(AZM_IDX_ZCTL, ctl, r);
		wr(AZM_IDX_ZTHR, thr, r);
		repeat (4) @(posedge frame_clock);
		@(posedge aclk);
		silent <= 1;
		repeat (n1) @(posedge frame_clock);
		chk({mute_left, mute_right}, 2'h0);
		repeat (n2 - n1) @(posedge frame_clock);
		chk({mute_left, mute_right}, e2);
		@(posedge aclk);
		silent <= 0;
		repeat (6) @(posedge frame_clock);
		chk({mute_left, mute_right}, 2'h0);
	endtask
	////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (3) @(posedge frame_clock);
		frame_rst_n <= 1;
	end
	// Run is near 16000 cycles; limit leaves wide margin
	initial
	begin
		#2400000;
		failures++;
		results;
	end
	initial
	begin
		logic [31:0] d;
		logic [1:0] r;
		waitc(3);
		aresetn <= 1;
		rchk(AZM_IDX_ENABLE, AZM_RST_ENABLE);
		rchk(AZM_IDX_ZTHR, AZM_RST_ZTHR);
		rchk(AZM_IDX_RAMP, AZM_RST_RAMP);
		rchk(AZM_IDX_EMRG, AZM_RST_EMRG);
		rchk(AZM_IDX_ZCTL, AZM_RST_ZCTL);
		chk(play_enable, 1'b0);
		rd(8'h7F, d, r);
		chk(r, 2'h2);
		wr(8'h7E, 8'h00, r);
		chk(r, 2'h2);
		wr(AZM_IDX_ENABLE, 8'h00, r);
		waitc(2);
		chk(play_enable, 1'b1);
		zrun(8'h07, 8'h00, 1000, 1040, 2'h3);
		zrun(8'h07, 8'h10, 5000, 5160, 2'h3);
		zrun(8'h03, 8'h70, 1000, 1040, 2'h3);
		zrun(8'h02, 8'h00, 1000, 1040, 2'h1);
		zrun(8'h01, 8'h00, 1000, 1040, 2'h2);
		wr(AZM_IDX_RAMP, 8'hC8, r);
		rchk(AZM_IDX_RAMP, 8'hC8);
		waitc(10);
		chk(volume_atten, 8'h00);
		wr(AZM_IDX_VOLUME, 8'h40, r);
		repeat (16) @(posedge frame_clock);
		chk(volume_atten inside {[8'h10:8'h30]}, 1'b1);
		repeat (28) @(posedge frame_clock);
		chk(volume_atten, 8'h40);
		@(posedge aclk);
		clock_error <= 1;
		repeat (12) @(posedge frame_clock);
		chk(volume_atten inside {[8'h80:8'hC0]}, 1'b1);
		repeat (28) @(posedge frame_clock);
		chk(volume_atten, 8'hFF);
		@(posedge aclk);
		clock_error <= 0;
		waitc(20);
		chk(volume_atten, 8'h40);
		// Every second sample: 1 dB steps down, 2 dB steps up
		wr(AZM_IDX_RAMP, 8'h56, r);
		wr(AZM_IDX_VOLUME, 8'h50, r);
		repeat (8) @(posedge frame_clock);
		chk(volume_atten inside {[8'h46:8'h4A]}, 1'b1);
		repeat (24) @(posedge frame_clock);
		chk(volume_atten, 8'h50);
		wr(AZM_IDX_VOLUME, 8'h40, r);
		repeat (20) @(posedge frame_clock);
		chk(volume_atten, 8'h40);
		wr(AZM_IDX_EMRG, 8'hC0, r);
		supply_fail <= 1;
		waitc(12);
		chk(volume_atten, 8'hFF);
		supply_fail <= 0;
		chk(amp_cfg.reserved, 1'b1);
		gain_freq_strap <= 3'h5;
		waitc(2);
		power_stage_up <= 1;
		waitc(10);
		chk(amp_cfg, {8'h1A, 4'h5, 16'h03C0, 1'b0});
		gain_freq_strap <= 3'h0;
		waitc(10);
		chk(amp_cfg, {8'h1A, 4'h5, 16'h03C0, 1'b0});
		rate_family_441 <= 1;
		power_stage_up <= 0;
		gain_freq_strap <= 3'h2;
		waitc(10);
		power_stage_up <= 1;
		waitc(10);
		chk(amp_cfg, {8'h14, 4'h6, 16'h0372, 1'b0});
		power_stage_up <= 0;
		gain_freq_strap <= 3'h7;
		waitc(10);
		power_stage_up <= 1;
		waitc(10);
		chk(amp_cfg.reserved, 1'b1);
		results;
	end
endmodule
